// file: logic/hop_cipher.sv
// iterative 32-bit block scrambler with 64-bit secret, one round per clock
// assumes start pulses only while idle; key and plain stay stable while busy
`timescale 1ns/1ps
`default_nettype none

module hop_cipher
	import hop_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        start,
	input  wire logic [63:0] secret,
	input  wire logic [31:0] plain,
	output logic             busy,
	output logic [31:0]      result
);
	logic [63:0] key_r;
	logic [9:0]  round_r;
	logic [4:0]  nlf_idx;
	logic        fb;

	assign nlf_idx = {result[31], result[26], result[20], result[9], result[1]};
	// nonlinear feedback over state taps and the rotating secret
	assign fb = CIPHER_NLF[nlf_idx] ^ result[0] ^ result[16] ^ key_r[0];

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			result  <= 32'h00000000;
			key_r   <= 64'h0000000000000000;
			round_r <= 10'h000;
			busy    <= 1'b0;
		end
		else if (start)
		begin
			result  <= plain;
			key_r   <= secret;
			round_r <= CIPHER_ROUNDS;
			busy    <= 1'b1;
		end
		else if (busy)
		begin
			result  <= {fb, result[31:1]};
			key_r   <= {key_r[0], key_r[63:1]};
			round_r <= round_r - 10'h001;
			busy    <= (round_r != 10'h001);
		end
	end

endmodule // hop_cipher

`default_nettype wire

// file: logic/hop_pkg.sv
// constants, field layout and states of the hopping code encoder core
// assumes a single 25 MHz clock domain and flop-based parameter store
`default_nettype none

package hop_pkg;

	// ----------------------------------------------------------------
	// store layout
	// ----------------------------------------------------------------
	localparam int          STORE_WORDS         = 12;
	localparam logic [3:0]  ADDR_CIPHER_SECRET_W0 = 4'h0;
	localparam logic [3:0]  ADDR_CIPHER_SECRET_W1 = 4'h1;
	localparam logic [3:0]  ADDR_CIPHER_SECRET_W2 = 4'h2;
	localparam logic [3:0]  ADDR_CIPHER_SECRET_W3 = 4'h3;
	localparam logic [3:0]  ADDR_HOP_COUNTER_WORD = 4'h4;
	localparam logic [3:0]  ADDR_SPARE_WORD_A     = 4'h5;
	localparam logic [3:0]  ADDR_UNIT_ID_LOW      = 4'h6;
	localparam logic [3:0]  ADDR_UNIT_ID_HIGH     = 4'h7;
	localparam logic [3:0]  ADDR_LEARN_SEED_LOW   = 4'h8;
	localparam logic [3:0]  ADDR_LEARN_SEED_HIGH  = 4'h9;
	localparam logic [3:0]  ADDR_SPARE_WORD_B     = 4'hA;
	localparam logic [3:0]  ADDR_OPTION_WORD      = 4'hB;
	localparam logic [15:0] STORE_RESET           = 16'h0000;

	// ----------------------------------------------------------------
	// option word and unit id fields
	// ----------------------------------------------------------------
	localparam int OPT_DISC_LSB      = 0;
	localparam int OPT_DISC_MSB      = 9;
	localparam int OPT_WRAP_FIRST    = 10;
	localparam int OPT_WRAP_SECOND   = 11;
	localparam int OPT_BATTERY_TRIP  = 12;
	localparam int OPT_RATE_LO       = 13;
	localparam int OPT_RATE_HI       = 14;
	localparam int OPT_RESERVED      = 15;
	localparam int UNIT_ID_SHUTOFF   = 15;
	localparam int UNIT_ID_TX_BITS   = 28;

	// ----------------------------------------------------------------
	// code word
	// ----------------------------------------------------------------
	localparam int          CODE_BITS     = 66;
	localparam logic [6:0]  LAST_BIT      = 7'd65;
	localparam logic [3:0]  ALL_BUTTONS   = 4'hF;
	localparam logic [1:0]  PHASES_PER_BIT = 2'd3;
	localparam logic [3:0]  GUARD_ELEMENTS = 4'd10;
	localparam logic [9:0]  CIPHER_ROUNDS = 10'd528;
	localparam logic [31:0] CIPHER_NLF    = 32'h3A5C742E;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam longint CLOCK_HZ       = 25000000;
	localparam longint DEBOUNCE_MS    = 10;
	localparam longint SHUTOFF_S      = 25;
	localparam longint ELEMENT_SLOW_US = 400;
	localparam longint ELEMENT_MID_US  = 200;
	localparam longint ELEMENT_FAST_US = 100;
	localparam longint BLINK_HALF_MS   = 100;
	localparam int unsigned DEBOUNCE_CYC  = int'(CLOCK_HZ * DEBOUNCE_MS / 1000);
	localparam int unsigned SHUTOFF_CYC   = int'(CLOCK_HZ * SHUTOFF_S);
	localparam int unsigned ELEM_SLOW_CYC = int'(CLOCK_HZ * ELEMENT_SLOW_US / 1000000);
	localparam int unsigned ELEM_MID_CYC  = int'(CLOCK_HZ * ELEMENT_MID_US / 1000000);
	localparam int unsigned ELEM_FAST_CYC = int'(CLOCK_HZ * ELEMENT_FAST_US / 1000000);
	localparam int unsigned BLINK_CYC     = int'(CLOCK_HZ * BLINK_HALF_MS / 1000);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE     = 7'h01,
		ST_DEBOUNCE = 7'h02,
		ST_ENCRYPT  = 7'h04,
		ST_SEND     = 7'h08,
		ST_TIMEOUT  = 7'h10,
		ST_PROG     = 7'h20,
		ST_LATCH    = 7'h40
	} enc_state_e;

endpackage

`default_nettype wire

// file: logic/hopping_code_encoder_core.sv
// control core of a button-woken code hopping transmitter encoder
// assumes button, programming and battery pins are asynchronous to clock
`timescale 1ns/1ps
`default_nettype none

module hopping_code_encoder_core
	import hop_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES = hop_pkg::DEBOUNCE_CYC,
	parameter int unsigned SHUTOFF_CYCLES  = hop_pkg::SHUTOFF_CYC,
	parameter int unsigned ELEM_SLOW       = hop_pkg::ELEM_SLOW_CYC,
	parameter int unsigned ELEM_MID        = hop_pkg::ELEM_MID_CYC,
	parameter int unsigned ELEM_FAST       = hop_pkg::ELEM_FAST_CYC,
	parameter int unsigned BLINK_CYCLES    = hop_pkg::BLINK_CYC
)
(
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic button_input_0,
	input  wire logic button_input_1,
	input  wire logic button_input_2,
	input  wire logic button_input_3,
	input  wire logic prog_mode,
	input  wire logic battery_low,
	input  wire logic code_pin_in,
	output logic      code_pin_out,
	output logic      code_pin_oe,
	output logic      indicator_cathode,
	output logic      battery_trip_select,
	output logic      awake
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [6:0]  pin_s1_r;
	logic [6:0]  pin_s2_r;
	logic [3:0]  buttons;
	logic        prog_sync;
	logic        low_sync;
	logic        data_sync;
	logic        pclk_prev_r;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_s1_r <= 7'h00;
			pin_s2_r <= 7'h00;
		end
		else
		begin
			pin_s1_r <= {code_pin_in, battery_low, prog_mode, button_input_3,
				button_input_2, button_input_1, button_input_0};
			pin_s2_r <= pin_s1_r;
		end
	end

	assign buttons   = pin_s2_r[3:0];
	assign prog_sync = pin_s2_r[4];
	assign low_sync  = pin_s2_r[5];
	assign data_sync = pin_s2_r[6];

	// ----------------------------------------------------------------
	// parameter store
	// ----------------------------------------------------------------
	// twelve words
	logic [15:0] store_r [STORE_WORDS];
	logic [63:0] secret;
	logic [31:0] unit_id;
	logic [31:0] seed;
	logic [15:0] option;
	logic [15:0] sync_nxt;
	logic [15:0] option_nxt;

	assign secret  = {store_r[ADDR_CIPHER_SECRET_W3], store_r[ADDR_CIPHER_SECRET_W2],
		store_r[ADDR_CIPHER_SECRET_W1], store_r[ADDR_CIPHER_SECRET_W0]};
	assign unit_id = {store_r[ADDR_UNIT_ID_HIGH], store_r[ADDR_UNIT_ID_LOW]};
	assign seed    = {store_r[ADDR_LEARN_SEED_HIGH], store_r[ADDR_LEARN_SEED_LOW]};
	assign option  = store_r[ADDR_OPTION_WORD];
	assign battery_trip_select = option[OPT_BATTERY_TRIP];

	// ----------------------------------------------------------------
	// state and counters
	// ----------------------------------------------------------------
	enc_state_e  state_r;
	logic [31:0] wait_r;
	logic [31:0] shutoff_r;
	logic [3:0]  latched_r;
	logic        wraps_r;
	logic        cipher_start;
	logic        cipher_busy;
	logic [31:0] cipher_out;
	logic [31:0] plain;
	logic        word_done;
	logic        new_button;
	logic        shutoff_hit;
	logic [4:0]  prog_cnt_r;
	logic [3:0]  prog_addr_r;
	logic [15:0] prog_shift_r;
	logic        prog_word;

	// a button not in the latched set
	assign new_button  = |(buttons & ~latched_r);
	// unit id bit 31 gates the shutoff
	assign shutoff_hit = unit_id[31] && (shutoff_r >= SHUTOFF_CYCLES - 1);
	// counter, discrimination, wrap flags and buttons go into the cipher
	assign plain = {latched_r, option[OPT_WRAP_SECOND:OPT_WRAP_FIRST],
		option[OPT_DISC_MSB:OPT_DISC_LSB], store_r[ADDR_HOP_COUNTER_WORD]};
	assign cipher_start = (state_r == ST_LATCH) && (latched_r != ALL_BUTTONS);
	assign awake = (state_r != ST_IDLE);

	always_comb
	begin
		sync_nxt   = store_r[ADDR_HOP_COUNTER_WORD] + 16'h0001;
		option_nxt = option;
		// wrap clears a flag; nothing here ever sets one
		if (store_r[ADDR_HOP_COUNTER_WORD] == 16'hFFFF)
		begin
			if (option[OPT_WRAP_FIRST])
				option_nxt[OPT_WRAP_FIRST] = 1'b0;
			else
				option_nxt[OPT_WRAP_SECOND] = 1'b0;
		end
		option_nxt[OPT_RESERVED] = 1'b0;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r   <= ST_IDLE;
			latched_r <= 4'h0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					if (prog_sync)
						state_r <= ST_PROG;
					else if (|buttons)
						state_r <= ST_DEBOUNCE;
				end
				ST_DEBOUNCE:
				begin
					// sample only after the debounce wait
					if (wait_r >= DEBOUNCE_CYCLES - 1)
					begin
						latched_r <= buttons;
						state_r   <= (|buttons) ? ST_LATCH : ST_IDLE;
					end
				end
				ST_LATCH:
					state_r <= ST_ENCRYPT;
				ST_ENCRYPT:
				begin
					if (!cipher_busy)
						state_r <= ST_SEND;
				end
				ST_SEND:
				begin
					if (shutoff_hit)
						state_r <= ST_TIMEOUT;
					// abandon the word and restart at once
					else if (new_button)
					begin
						latched_r <= buttons;
						state_r   <= ST_LATCH;
					end
					// power down only once all buttons are gone
					else if (word_done && !(|buttons))
						state_r <= ST_IDLE;
				end
				ST_TIMEOUT:
				begin
					// silent until every button is released
					if (!(|buttons))
						state_r <= ST_IDLE;
				end
				ST_PROG:
				begin
					if (!prog_sync)
						state_r <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wait_r    <= 32'h00000000;
			shutoff_r <= 32'h00000000;
		end
		else if (state_r == ST_IDLE)
		begin
			wait_r    <= 32'h00000000;
			shutoff_r <= 32'h00000000;
		end
		else
		begin
			wait_r <= wait_r + 32'h00000001;
			if (shutoff_r != 32'hFFFFFFFF)
				shutoff_r <= shutoff_r + 32'h00000001;
		end
	end

	// ----------------------------------------------------------------
	// store writes: programming and counter write-back
	// ----------------------------------------------------------------
	assign prog_word = (state_r == ST_PROG) && pin_s2_r[2] && !pclk_prev_r
		&& (prog_cnt_r == 5'd15);

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < STORE_WORDS; i++)
				store_r[i] <= STORE_RESET;
		end
		// write-back lands before the code word goes out
		else if (state_r == ST_LATCH)
		begin
			store_r[ADDR_HOP_COUNTER_WORD] <= sync_nxt;
			store_r[ADDR_OPTION_WORD]      <= option_nxt;
		end
		else if (prog_word && (prog_addr_r < 4'(STORE_WORDS)))
			store_r[prog_addr_r] <= {data_sync, prog_shift_r[15:1]};
	end

	// button two clocks in data, lsb first, words in address order
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			pclk_prev_r  <= 1'b0;
			prog_cnt_r   <= 5'd0;
			prog_addr_r  <= 4'h0;
			prog_shift_r <= 16'h0000;
		end
		else
		begin
			pclk_prev_r <= pin_s2_r[2];
			if (state_r != ST_PROG)
			begin
				prog_cnt_r  <= 5'd0;
				prog_addr_r <= 4'h0;
			end
			else if (pin_s2_r[2] && !pclk_prev_r)
			begin
				prog_shift_r <= {data_sync, prog_shift_r[15:1]};
				prog_cnt_r   <= (prog_cnt_r == 5'd15) ? 5'd0 : prog_cnt_r + 5'd1;
				if (prog_cnt_r == 5'd15)
					prog_addr_r <= prog_addr_r + 4'h1;
			end
		end
	end

	hop_cipher u_cipher (
		.clock  (clock),
		.resetn (resetn),
		.start  (cipher_start),
		.secret (secret),
		.plain  (plain),
		.busy   (cipher_busy),
		.result (cipher_out)
	);

	// ----------------------------------------------------------------
	// serialiser
	// ----------------------------------------------------------------
	logic [65:0] word_r;
	logic        rpt_r;
	logic [31:0] elem_r;
	logic [31:0] elem_len;
	logic [1:0]  phase_r;
	logic [6:0]  bit_r;
	logic        guard_r;
	logic [3:0]  guard_cnt_r;
	logic [1:0]  word_num_r;
	logic        visible;
	logic        elem_end;
	logic        pulse_hi;

	// element length and blanking from the rate pair
	always_comb
	begin
		unique case ({option[OPT_RATE_HI], option[OPT_RATE_LO]})
			2'b00:   elem_len = ELEM_SLOW;
			2'b01:   elem_len = ELEM_MID;
			default: elem_len = ELEM_FAST;
		endcase
		unique case ({option[OPT_RATE_HI], option[OPT_RATE_LO]})
			2'b00:   visible = 1'b1;
			2'b11:   visible = (word_num_r == 2'd0);
			default: visible = !word_num_r[0];
		endcase
	end

	assign elem_end  = (elem_r >= elem_len - 1);
	assign word_done = guard_r && elem_end && (guard_cnt_r == GUARD_ELEMENTS - 4'd1);
	// one element high for a one, two for a zero
	assign pulse_hi  = word_r[bit_r] ? (phase_r == 2'd0) : (phase_r != 2'd2);

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			word_r      <= 66'h0;
			rpt_r       <= 1'b0;
			elem_r      <= 32'h00000000;
			phase_r     <= 2'd0;
			bit_r       <= 7'd0;
			guard_r     <= 1'b0;
			guard_cnt_r <= 4'h0;
			word_num_r  <= 2'd0;
		end
		else if (state_r != ST_SEND)
		begin
			elem_r      <= 32'h00000000;
			phase_r     <= 2'd0;
			bit_r       <= 7'd0;
			guard_r     <= 1'b0;
			guard_cnt_r <= 4'h0;
			if (state_r == ST_ENCRYPT && !cipher_busy)
			begin
				// 32 encrypted bits then 34 fixed bits
				// only 28 unit id bits travel
				// seed replaces the hopping part with all buttons
				word_r <= {rpt_r, low_sync, latched_r, unit_id[UNIT_ID_TX_BITS-1:0],
					(latched_r == ALL_BUTTONS) ? seed : cipher_out};
			end
			if (state_r == ST_IDLE)
			begin
				rpt_r      <= 1'b0;
				word_num_r <= 2'd0;
			end
		end
		else if (new_button)
		begin
			elem_r <= 32'h00000000;
		end
		else
		begin
			elem_r <= elem_end ? 32'h00000000 : elem_r + 32'h00000001;
			if (elem_end && !guard_r)
			begin
				phase_r <= (phase_r == PHASES_PER_BIT - 2'd1) ? 2'd0 : phase_r + 2'd1;
				if (phase_r == PHASES_PER_BIT - 2'd1)
				begin
					bit_r   <= (bit_r == LAST_BIT) ? 7'd0 : bit_r + 7'd1;
					guard_r <= (bit_r == LAST_BIT);
				end
			end
			else if (elem_end)
			begin
				guard_cnt_r <= guard_cnt_r + 4'h1;
				if (word_done)
				begin
					// held buttons repeat the same word, flagged as repeat
					guard_r        <= 1'b0;
					guard_cnt_r    <= 4'h0;
					word_num_r     <= word_num_r + 2'd1;
					rpt_r          <= 1'b1;
					word_r[65]     <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	logic [31:0] blink_r;
	logic        blink_state_r;
	logic        code_r;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			code_r        <= 1'b0;
			blink_r       <= 32'h00000000;
			blink_state_r <= 1'b0;
		end
		else
		begin
			code_r <= (state_r == ST_SEND) && !guard_r && visible && pulse_hi && !new_button;
			if (state_r != ST_SEND)
			begin
				blink_r       <= 32'h00000000;
				blink_state_r <= 1'b0;
			end
			else if (blink_r >= BLINK_CYCLES - 1)
			begin
				blink_r       <= 32'h00000000;
				blink_state_r <= !blink_state_r;
			end
			else
				blink_r <= blink_r + 32'h00000001;
		end
	end

	// pin released while the programmer drives data
	assign code_pin_oe  = (state_r != ST_PROG);
	assign code_pin_out = code_r;
	// lit (low) while sending; blinks when the battery is low
	assign indicator_cathode = !((state_r == ST_SEND) && !(low_sync && blink_state_r));

endmodule // hopping_code_encoder_core

`default_nettype wire

// file: verif/hop_core_sva.sv
// port checker for the encoder core
// assumes bind onto hopping_code_encoder_core, one clock domain
`timescale 1ns/1ps
`default_nettype none
module hop_core_sva
#(
	parameter int unsigned DEBOUNCE_CYCLES = 20,
	parameter int unsigned ELEM_SLOW       = 8
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic button_input_0,
	input wire logic button_input_1,
	input wire logic button_input_2,
	input wire logic button_input_3,
	input wire logic prog_mode,
	input wire logic battery_low,
	input wire logic code_pin_in,
	input wire logic code_pin_out,
	input wire logic code_pin_oe,
	input wire logic indicator_cathode,
	input wire logic battery_trip_select,
	input wire logic awake
);
	// generous: debounce, cipher and two slow words with guard
	localparam int unsigned REL_MAX = DEBOUNCE_CYCLES + 600 + 416 * ELEM_SLOW;
	logic [31:0] wake_cnt_r;
	logic [31:0] rel_cnt_r;
	logic [31:0] hi_cnt_r;
	logic [3:0]  pm_low_r;
	wire logic   any_btn = button_input_0 | button_input_1 | button_input_2 | button_input_3;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// ----------------
	// helper counters
	// ----------------
	always_ff @(posedge clock or negedge resetn)
		if (!resetn)
		begin
			wake_cnt_r <= '0;
			rel_cnt_r  <= '0;
			hi_cnt_r   <= '0;
			pm_low_r   <= '0;
		end
		else
		begin
			wake_cnt_r <= awake ? wake_cnt_r + 32'h1 : '0;
			rel_cnt_r  <= (awake && !any_btn && !prog_mode) ? rel_cnt_r + 32'h1 : '0;
			hi_cnt_r   <= code_pin_out ? hi_cnt_r + 32'h1 : '0;
			pm_low_r   <= prog_mode ? '0 : ((pm_low_r == 4'hF) ? pm_low_r : pm_low_r + 4'h1);
		end
	a_wake_button: assert property ((any_btn && !prog_mode) [*6] |-> awake)
		else $error("buttons held, encoder asleep");
	a_debounce_wait: assert property (code_pin_out |-> wake_cnt_r > DEBOUNCE_CYCLES)
		else $error("output before debounce ended");
	a_idle_quiet: assert property (!awake |-> !code_pin_out)
		else $error("output while asleep");
	a_led_dark: assert property (!awake |-> indicator_cathode)
		else $error("indicator lit while asleep");
	a_release_done: assert property (rel_cnt_r < REL_MAX)
		else $error("no power down after release");
	a_pulse_width: assert property (code_pin_out |-> hi_cnt_r < 2 * ELEM_SLOW)
		else $error("carrier pulse too long");
	a_prog_exit: assert property (!code_pin_oe |-> pm_low_r < 4'h5)
		else $error("pin released outside programming");
	a_prog_silent: assert property (!code_pin_oe |-> !code_pin_out)
		else $error("modulating while pin released");
	a_trip_stable: assert property ($changed(battery_trip_select) |-> !$past(code_pin_oe))
		else $error("trip select changed outside programming");
	c_wake: cover property ($rose(awake));
	c_prog: cover property ($fell(code_pin_oe));
	c_release: cover property (rel_cnt_r == 32'hA);
endmodule // hop_core_sva
bind hopping_code_encoder_core hop_core_sva
	#(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .ELEM_SLOW(ELEM_SLOW)) i_sva (
	.clock(clock), .resetn(resetn), .button_input_0(button_input_0),
	.button_input_1(button_input_1), .button_input_2(button_input_2),
	.button_input_3(button_input_3), .prog_mode(prog_mode), .battery_low(battery_low),
	.code_pin_in(code_pin_in), .code_pin_out(code_pin_out), .code_pin_oe(code_pin_oe),
	.indicator_cathode(indicator_cathode), .battery_trip_select(battery_trip_select),
	.awake(awake));
`default_nettype wire

// file: verif/hop_receiver.sv
// receiver model: recovers 66-bit code words from the modulated pin
// assumes rate 00 timing, element of ELEM clocks
`timescale 1ns/1ps
`default_nettype none
module hop_receiver
#(
	parameter int unsigned ELEM = 8
)
(
	input  wire logic   clock,
	input  wire logic   resetn,
	input  wire logic   code_pin_out,
	output logic        word_valid,
	output logic [65:0] word
);
	logic [15:0] hi_r;
	logic [15:0] lo_r;
	logic [6:0]  n_r;
	// ----------------
	// pulse decoding
	// ----------------
	always_ff @(posedge clock or negedge resetn)
		if (!resetn)
		begin
			hi_r       <= '0;
			lo_r       <= '0;
			n_r        <= '0;
			word_valid <= 1'b0;
			word       <= '0;
		end
		else
		begin
			word_valid <= 1'b0;
			hi_r       <= code_pin_out ? hi_r + 16'h1 : '0;
			lo_r       <= code_pin_out ? '0 : lo_r + 16'h1;
			// short high is one, 66 bits per word
			if (!code_pin_out && hi_r != '0)
			begin
				word[n_r]  <= hi_r < 16'(3 * ELEM / 2);
				n_r        <= (n_r == 7'h41) ? '0 : n_r + 7'h1;
				word_valid <= n_r == 7'h41;
			end
			// long gap drops a half-seen (aborted) word
			else if (lo_r > 16'(4 * ELEM))
				n_r <= '0;
		end
endmodule // hop_receiver
`default_nettype wire

// file: verif/hopping_code_encoder_core_tb.sv
// self-checking bench for the hopping code encoder core
// assumes shortened timing parameters and the receiver model
`timescale 1ns/1ps
`default_nettype none
module hopping_code_encoder_core_tb;
	import hop_pkg::*;
	localparam int unsigned DEB   = 20;
	localparam int unsigned SHUT  = 5000;
	localparam int unsigned ES    = 8;
	localparam logic [65:0] FULL  = '1;
	localparam logic [65:0] NOHOP = {34'h3FFFFFFFF, 32'h0};
	localparam logic [65:0] NORPT = {1'h0, 33'h1FFFFFFFF, 32'h0};
	logic        clock;
	logic        resetn;
	logic [3:0]  btn;
	logic [3:0]  b;
	logic        prog_mode;
	logic        battery_low;
	logic        prog_data;
	logic        allow_extra;
	logic [15:0] store [12];
	logic [65:0] exp_q [$];
	logic [65:0] msk_q [$];
	int          err_count, samples_checked, words_seen, seed, hi;
	wire logic   code_pin_out, code_pin_oe, awake, battery_trip_select, word_valid;
	wire logic   indicator_cathode;
	wire logic [65:0] word_seen;
	// pin level: encoder while it drives, else the programmer
	wire logic   code_pin_in = code_pin_oe ? code_pin_out : prog_data;
	hopping_code_encoder_core #(.DEBOUNCE_CYCLES(DEB), .SHUTOFF_CYCLES(SHUT), .ELEM_SLOW(ES),
		.ELEM_MID(4), .ELEM_FAST(2), .BLINK_CYCLES(16)) i_dut (
		.clock(clock), .resetn(resetn), .button_input_0(btn[0]), .button_input_1(btn[1]),
		.button_input_2(btn[2]), .button_input_3(btn[3]), .prog_mode(prog_mode),
		.battery_low(battery_low), .code_pin_in(code_pin_in), .code_pin_out(code_pin_out),
		.code_pin_oe(code_pin_oe), .indicator_cathode(indicator_cathode), .awake(awake),
		.battery_trip_select(battery_trip_select));
	hop_receiver #(.ELEM(ES)) i_rx (.clock(clock), .resetn(resetn),
		.code_pin_out(code_pin_out), .word_valid(word_valid), .word(word_seen));
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic check(input logic [65:0] seen, input logic [65:0] expv);
		samples_checked++;
		if (seen !== expv)
		begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, expv);
		end
	endtask
	// decoder side: undo the scrambling rounds, last round first
	function automatic logic [31:0] unscramble(input logic [31:0] c);
		logic [63:0] k;
		logic [31:0] s;
		k = {store[3], store[2], store[1], store[0]};
		s = c;
		for (int i = int'(CIPHER_ROUNDS) - 1; i >= 0; i--)
			s = {s[30:0], s[31] ^ CIPHER_NLF[{s[30], s[25], s[19], s[8], s[0]}]
				^ s[15] ^ k[i % 64]};
		return s;
	endfunction
	task automatic cycles(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ----------------
	// programmer, notes and waits
	// ----------------
	task automatic program_store();
		prog_mode <= 1'b1;
		cycles(8);
		for (int w = 0; w < STORE_WORDS; w++)
			for (int i = 0; i < 16; i++)
			begin
				prog_data <= store[w][i];
				cycles(3);
				btn[2] <= 1'b1;
				cycles(4);
				btn[2] <= 1'b0;
				cycles(3);
			end
		prog_mode <= 1'b0;
		cycles(8);
	endtask
	task automatic note(input logic [3:0] bt, input logic vl, input logic rp, input logic [65:0] m,
		input logic [31:0] hp);
		exp_q.push_back({rp, vl, bt, store[7][11:0], store[6], hp});
		msk_q.push_back(m);
	endtask
	task automatic wait_words(input int n);
		for (int i = 0; i < 20000 && words_seen < n; i++)
			@(posedge clock);
		if (words_seen < n)
		begin
			err_count++;
			$display("[ERR] %0t word wait expired", $time);
		end
	endtask
	task automatic wait_high();
		for (int i = 0; i < 2000 && code_pin_out !== 1'b1; i++)
			@(posedge clock);
		if (code_pin_out !== 1'b1)
		begin
			err_count++;
			$display("[ERR] %0t no carrier seen", $time);
		end
	endtask
	always @(posedge clock)
		if (word_valid === 1'b1)
		begin : take_word
			logic [65:0] m;
			logic [65:0] e;
			words_seen <= words_seen + 1;
			if (msk_q.size() != 0)
			begin
				m = msk_q.pop_front();
				e = exp_q.pop_front();
				check(word_seen & m, e & m);
				if (!m[0])
					check(66'(unscramble(word_seen[31:0])), 66'(e[31:0]));
			end
			else if (!allow_extra)
			begin
				err_count++;
				$display("[ERR] %0t unexpected word %h", $time, word_seen);
			end
		end
	initial
	begin
		repeat (60000) @(posedge clock);
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end
	initial
	begin
		{resetn, btn, prog_mode, battery_low, prog_data, allow_extra} = '0;
		{err_count, samples_checked, words_seen} = '0;
		seed = 32'hBE89;
		cycles(20);
		resetn <= 1'b1;
		cycles(4);
		for (int w = 0; w < STORE_WORDS; w++)
			store[w] = 16'($random(seed));
		// spare words zero; counter just short of wrap
		store[ADDR_SPARE_WORD_A] = 16'h0000;
		store[ADDR_SPARE_WORD_B] = 16'h0000;
		store[ADDR_HOP_COUNTER_WORD] = 16'hFFFE;
		store[ADDR_UNIT_ID_HIGH][15] = 1'b0;
		// wrap flags set, high trip, rate 00, bit 15 clear
		store[ADDR_OPTION_WORD][15:10] = 6'h07;
		program_store();
		check(66'(battery_trip_select), 66'h1);
		$display("test program done");
		b = 4'($random(seed));
		if (b == 4'h0 || b == ALL_BUTTONS)
			b = 4'h1;
		note(b, 1'h0, 1'h0, NOHOP,
			{b, 2'h3, store[ADDR_OPTION_WORD][9:0], store[ADDR_HOP_COUNTER_WORD]});
		btn <= b;
		wait_high();
		check(66'(indicator_cathode), 66'h0);
		btn <= 4'h0;
		wait_words(1);
		cycles(16 * ES);
		check(66'(awake), 66'h0);
		$display("test release done");
		battery_low <= 1'b1;
		note(ALL_BUTTONS, 1'h1, 1'h0, FULL, {store[9], store[8]});
		note(ALL_BUTTONS, 1'h1, 1'h1, FULL, {store[9], store[8]});
		btn <= ALL_BUTTONS;
		wait_words(3);
		btn <= 4'h0;
		battery_low <= 1'b0;
		cycles(16 * ES);
		$display("test seed done");
		// seed pass wrapped the counter; aborted word took 0000
		note(4'h3, 1'h0, 1'h0, NORPT, {4'h3, 2'h2, store[ADDR_OPTION_WORD][9:0], 16'h0001});
		btn <= 4'h1;
		wait_high();
		cycles(50);
		btn <= 4'h3;
		wait_words(4);
		btn <= 4'h0;
		cycles(16 * ES);
		check(66'(words_seen), 66'h4);
		$display("test restart done");
		store[ADDR_UNIT_ID_HIGH][15] = 1'b1;
		program_store();
		allow_extra = 1'b1;
		btn <= 4'h8;
		cycles(SHUT + 200);
		hi = 0;
		repeat (2000)
		begin
			@(posedge clock);
			if (code_pin_out !== 1'b0)
				hi++;
		end
		check(66'(hi), 66'h0);
		check(66'(awake), 66'h1);
		btn <= 4'h0;
		cycles(10);
		check(66'(awake), 66'h0);
		$display("test shutoff done");
		conclude();
	end
endmodule // hopping_code_encoder_core_tb
`default_nettype wire
